// file: pkg/temp_dac_pkg.sv
/*
  Shared constants for the temperature driven dual DAC word path:
  register indices, field positions, reset values, keys and timing.
  Assumes a single 40 MHz system clock and an AXI4-Lite register bus.
*/
`default_nettype none
package temp_dac_pkg;
  // ==========================================================
  // timing
  localparam int SYS_CLK_HZ       = 40_000_000;
  localparam int SAMPLE_PERIOD_MS = 25;
  localparam int SAMPLE_CYCLES    = SYS_CLK_HZ / 1000 * SAMPLE_PERIOD_MS;

  // ==========================================================
  // widths
  localparam int WORD_W = 12;
  localparam int ADDR_W = 8;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_SENSOR_HIGH = 6'h00;
  localparam logic [5:0] IDX_SENSOR_LOW  = 6'h01;
  localparam logic [5:0] IDX_CALC0_HIGH  = 6'h02;
  localparam logic [5:0] IDX_CALC0_LOW   = 6'h03;
  localparam logic [5:0] IDX_CALC1_HIGH  = 6'h04;
  localparam logic [5:0] IDX_CALC1_LOW   = 6'h05;
  localparam logic [5:0] IDX_ACCESS      = 6'h10;
  localparam logic [5:0] IDX_OVR_CTL     = 6'h11;
  localparam logic [5:0] IDX_FTEMP_HIGH  = 6'h12;
  localparam logic [5:0] IDX_FTEMP_LOW   = 6'h13;
  localparam logic [5:0] IDX_FDAC0_HIGH  = 6'h14;
  localparam logic [5:0] IDX_FDAC0_LOW   = 6'h15;
  localparam logic [5:0] IDX_FDAC1_HIGH  = 6'h16;
  localparam logic [5:0] IDX_FDAC1_LOW   = 6'h17;
  localparam logic [5:0] IDX_BASE0_HIGH  = 6'h18;
  localparam logic [5:0] IDX_BASE0_LOW   = 6'h19;
  localparam logic [5:0] IDX_BASE1_HIGH  = 6'h1A;
  localparam logic [5:0] IDX_BASE1_LOW   = 6'h1B;

  // ==========================================================
  // fields and values
  localparam int         OVR_TEMP_BIT    = 0;
  localparam int         OVR_DAC_BIT     = 1;
  localparam int         SKIP_BIT        = 7;
  localparam logic [1:0] OVR_CTL_RESET   = 2'h0;
  localparam logic [7:0] KEY_FIRST       = 8'hCD;
  localparam logic [7:0] KEY_SECOND      = 8'hF0;
  localparam logic [7:0] ACCESS_FULL_RD  = 8'h03;
  localparam logic [7:0] ACCESS_NONE_RD  = 8'h00;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // ==========================================================
  // sample path sequencing
  typedef enum logic [1:0] {
    PATH_IDLE = 2'b01,
    PATH_CALC = 2'b10
  } path_state_e;
endpackage
`default_nettype wire

// file: rtl/dac_source_mux.sv
/*
  One channel of the DAC source selection: computed word, constant_level_value word
  or host forced word, registered toward the DAC input.
  Assumes all inputs come from logic on sys_clk.
*/
`default_nettype none
module dac_source_mux
  import temp_dac_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic [WORD_W-1:0] computed_word,
  input  wire logic [WORD_W-1:0] constant_level_value_word,
  input  wire logic [WORD_W-1:0] forced_word,
  input  wire logic              alu_skip_bit,
  input  wire logic              dac_override_select,
  output logic      [WORD_W-1:0] dac_word
);
  typedef struct packed {
    logic [WORD_W-1:0] word;
  } mux_state_s;

  mux_state_s s_reg;
  mux_state_s s_next;

  // ==========================================================
  // selection
  // override sits after the skip mux, so it beats both sources
  always_comb begin
    s_next = s_reg;
    if (dac_override_select) begin
      s_next.word = forced_word;
    end else if (alu_skip_bit) begin
      s_next.word = constant_level_value_word;
    end else begin
      s_next.word = computed_word;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dac_word = s_reg.word;

  // ==========================================================
  // checks
  property p_normal_path;
    @(posedge sys_clk) disable iff (!reset_n)
      !dac_override_select && !alu_skip_bit |=> dac_word == $past(computed_word);
  endproperty
  a_normal_path: assert property (p_normal_path)
    else $error("computed word not forwarded");

  property p_skip_path;
    @(posedge sys_clk) disable iff (!reset_n)
      !dac_override_select && alu_skip_bit |=> dac_word == $past(constant_level_value_word);
  endproperty
  a_skip_path: assert property (p_skip_path)
    else $error("constant_level_value word not forwarded");

  property p_forced_path;
    @(posedge sys_clk) disable iff (!reset_n)
      dac_override_select |=> dac_word == $past(forced_word);
  endproperty
  a_forced_path: assert property (p_forced_path)
    else $error("forced word does not win");
endmodule
`default_nettype wire

// file: rtl/temp_dac_path_mode_control.sv
/*
  Temperature sample timing, ALU request sequencing, override and
  skip state, access unlock and the AXI4-Lite register slave.
  Assumes the sensor word is asynchronous and changes slowly, the ALU
  is external logic on sys_clk, and nv inputs are stable at reset.
*/
// Overview of operation
// - take a new sensor sample every 25 ms into the sensor reading registers
// - each new sample taken while no calculation runs starts an ALU recalculation producing new DAC words
// - without skip or override each channel's ALU result drives its DAC word
// - power-up leaves both override selects clear; runs without host access
// - control value 0x01 makes forced temperature feed the ALU instead of sensor
// - forced temperature is high register nibble above low register byte
// - forced temperature is a 12-bit two's complement value
// - high nibble writes wait; writing the low byte commits both halves
// - sensor reading registers keep real samples while temperature is forced
// - clearing the temperature select returns the ALU to sensor samples
// - override data and control registers are volatile and reset to zero
// - a set skip bit sends that channel's constant_level_value value to its DAC
// - skip bit restored at power-up; if set, constant_level_value appears at once
// - each channel has its own skip bit and constant_level_value value
// - DAC override takes each 12-bit word from forced high and low registers
// - one DAC override select switches both channels together
// - keys 0xCD then 0xF0 grant full write access; reading returns 0x03
// - control value 0x02 routes both forced words to the DACs
// - forced DAC words are 12-bit offset binary
`default_nettype none
module temp_dac_path_mode_control
  import temp_dac_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [WORD_W-1:0] sensor_temp,
  output logic                   alu_start,
  output logic      [WORD_W-1:0] alu_temp,
  input  wire logic              alu_done,
  input  wire logic [WORD_W-1:0] alu_word0,
  input  wire logic [WORD_W-1:0] alu_word1,
  input  wire logic [1:0]        nv_skip,
  input  wire logic [WORD_W-1:0] nv_base0,
  input  wire logic [WORD_W-1:0] nv_base1,
  output logic      [WORD_W-1:0] dac_word0,
  output logic      [WORD_W-1:0] dac_word1
);
  localparam int CNT_W = $clog2(SAMPLE_CYCLES_P);

  typedef struct packed {
    path_state_e             state;
    logic [CNT_W-1:0]        tick_cnt;
    logic [WORD_W-1:0]       sync1;
    logic [WORD_W-1:0]       sync2;
    logic [WORD_W-1:0]       sensor_reading;
    logic [1:0][WORD_W-1:0]  computed;
    logic                    alu_start;
    logic [WORD_W-1:0]       alu_temp;
    logic                    full_access;
    logic                    key_armed;
    logic [1:0]              ovr_ctl;
    logic [3:0]              temp_hold;
    logic [WORD_W-1:0]       forced_temp;
    logic [1:0][3:0]         dac_hold;
    logic [1:0][WORD_W-1:0]  forced_dac;
    logic [1:0]              skip;
    logic [1:0][WORD_W-1:0]  constant_level_value;
    logic                    nv_loaded;
    logic                    aw_held;
    logic                    w_held;
    logic [ADDR_W-1:0]       aw_addr;
    logic [7:0]              w_data;
    logic                    w_lane0;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [7:0]              rdata;
    logic [1:0]              rresp;
  } path_state_s;

  path_state_s s_reg;
  path_state_s s_next;

  logic              tick;
  logic              wr_exec;
  logic [5:0]        wr_idx;
  logic [8:0]        wr_probe;
  logic [8:0]        rd_probe;
  logic [1:0][WORD_W-1:0] dac_word;

  // ==========================================================
  // register read decode: {hit, byte}
  function automatic logic [8:0] read_reg(input logic [5:0] idx, input path_state_s st);
    logic [8:0] r;
    r = '0;
    unique case (idx)
      IDX_SENSOR_HIGH: r = {1'b1, 4'h0, st.sensor_reading[11:8]};
      IDX_SENSOR_LOW:  r = {1'b1, st.sensor_reading[7:0]};
      IDX_CALC0_HIGH:  r = {1'b1, 4'h0, st.computed[0][11:8]};
      IDX_CALC0_LOW:   r = {1'b1, st.computed[0][7:0]};
      IDX_CALC1_HIGH:  r = {1'b1, 4'h0, st.computed[1][11:8]};
      IDX_CALC1_LOW:   r = {1'b1, st.computed[1][7:0]};
      IDX_ACCESS:      r = {1'b1, st.full_access ? ACCESS_FULL_RD : ACCESS_NONE_RD};
      IDX_OVR_CTL:     r = {1'b1, 6'h00, st.ovr_ctl};
      IDX_FTEMP_HIGH:  r = {1'b1, 4'h0, st.forced_temp[11:8]};
      IDX_FTEMP_LOW:   r = {1'b1, st.forced_temp[7:0]};
      IDX_FDAC0_HIGH:  r = {1'b1, 4'h0, st.forced_dac[0][11:8]};
      IDX_FDAC0_LOW:   r = {1'b1, st.forced_dac[0][7:0]};
      IDX_FDAC1_HIGH:  r = {1'b1, 4'h0, st.forced_dac[1][11:8]};
      IDX_FDAC1_LOW:   r = {1'b1, st.forced_dac[1][7:0]};
      IDX_BASE0_HIGH:  r = {1'b1, st.skip[0], 3'h0, st.constant_level_value[0][11:8]};
      IDX_BASE0_LOW:   r = {1'b1, st.constant_level_value[0][7:0]};
      IDX_BASE1_HIGH:  r = {1'b1, st.skip[1], 3'h0, st.constant_level_value[1][11:8]};
      IDX_BASE1_LOW:   r = {1'b1, st.constant_level_value[1][7:0]};
      default:         r = '0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // bus handshakes
  assign awready  = !s_reg.aw_held;
  assign wready   = !s_reg.w_held;
  assign arready  = !s_reg.rvalid;
  assign wr_exec  = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  assign wr_idx   = s_reg.aw_addr[ADDR_W-1:2];
  assign wr_probe = read_reg(wr_idx, s_reg);
  assign rd_probe = read_reg(araddr[ADDR_W-1:2], s_reg);
  assign tick     = s_reg.tick_cnt == CNT_W'(SAMPLE_CYCLES_P - 1);

  // ==========================================================
  // next state
  always_comb begin
    s_next           = s_reg;
    s_next.alu_start = 1'b0;
    s_next.sync1     = sensor_temp;
    s_next.sync2     = s_reg.sync1;
    if (tick) begin
      s_next.tick_cnt       = '0;
      s_next.sensor_reading = s_reg.sync2;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + CNT_W'(1);
    end

    // a sample landing mid-calculation is kept but not recomputed
    unique case (s_reg.state)
      PATH_IDLE: begin
        if (tick) begin
          // forced word is two's complement, passed to the ALU as is
          s_next.alu_temp = s_reg.ovr_ctl[OVR_TEMP_BIT] ? s_reg.forced_temp
                                                        : s_reg.sync2;
          s_next.alu_start = 1'b1;
          s_next.state     = PATH_CALC;
        end
      end
      PATH_CALC: begin
        if (alu_done) begin
          s_next.computed[0] = alu_word0;
          s_next.computed[1] = alu_word1;
          s_next.state       = PATH_IDLE;
        end
      end
    endcase

    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_exec) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = wr_probe[8] ? RESP_OKAY : RESP_SLVERR;
      if (s_reg.w_lane0) begin
        if (wr_idx == IDX_ACCESS) begin
          if (s_reg.w_data == KEY_FIRST) begin
            s_next.key_armed = 1'b1;
          end else if (s_reg.w_data == KEY_SECOND && s_reg.key_armed) begin
            s_next.full_access = 1'b1;
            s_next.key_armed   = 1'b0;
          end else begin
            s_next.full_access = 1'b0;
            s_next.key_armed   = 1'b0;
          end
        end else if (s_reg.full_access) begin
          unique case (wr_idx)
            IDX_OVR_CTL:    s_next.ovr_ctl = s_reg.w_data[1:0];
            IDX_FTEMP_HIGH: s_next.temp_hold = s_reg.w_data[3:0];
            IDX_FTEMP_LOW:  s_next.forced_temp = {s_reg.temp_hold, s_reg.w_data};
            IDX_FDAC0_HIGH: s_next.dac_hold[0] = s_reg.w_data[3:0];
            IDX_FDAC0_LOW:  s_next.forced_dac[0] = {s_reg.dac_hold[0], s_reg.w_data};
            IDX_FDAC1_HIGH: s_next.dac_hold[1] = s_reg.w_data[3:0];
            IDX_FDAC1_LOW:  s_next.forced_dac[1] = {s_reg.dac_hold[1], s_reg.w_data};
            IDX_BASE0_HIGH: begin
              s_next.skip[0]        = s_reg.w_data[SKIP_BIT];
              s_next.constant_level_value[0][11:8]  = s_reg.w_data[3:0];
            end
            IDX_BASE0_LOW:  s_next.constant_level_value[0][7:0] = s_reg.w_data;
            IDX_BASE1_HIGH: begin
              s_next.skip[1]        = s_reg.w_data[SKIP_BIT];
              s_next.constant_level_value[1][11:8]  = s_reg.w_data[3:0];
            end
            IDX_BASE1_LOW:  s_next.constant_level_value[1][7:0] = s_reg.w_data;
            default: ;
          endcase
        end
      end
    end
    if (awvalid && awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_held  = 1'b1;
      s_next.w_data  = wdata[7:0];
      s_next.w_lane0 = wstrb[0];
    end

    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_probe[7:0];
      s_next.rresp  = rd_probe[8] ? RESP_OKAY : RESP_SLVERR;
    end

    // restore from storage on the first edge after reset release
    if (!s_reg.nv_loaded) begin
      s_next.skip      = nv_skip;
      s_next.constant_level_value[0]   = nv_base0;
      s_next.constant_level_value[1]   = nv_base1;
      s_next.nv_loaded = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_reg       <= '0;
      s_reg.state <= PATH_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // per channel source selection
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    dac_source_mux u_mux (
      .sys_clk             (sys_clk),
      .reset_n             (reset_n),
      .computed_word       (s_reg.computed[ch]),
      .constant_level_value_word           (s_reg.constant_level_value[ch]),
      .forced_word         (s_reg.forced_dac[ch]),
      .alu_skip_bit        (s_reg.skip[ch] && s_reg.nv_loaded),
      .dac_override_select (s_reg.ovr_ctl[OVR_DAC_BIT]),
      .dac_word            (dac_word[ch])
    );
  end

  assign dac_word0 = dac_word[0];
  assign dac_word1 = dac_word[1];
  assign alu_start = s_reg.alu_start;
  assign alu_temp  = s_reg.alu_temp;
  assign bvalid    = s_reg.bvalid;
  assign bresp     = s_reg.bresp;
  assign rvalid    = s_reg.rvalid;
  assign rresp     = s_reg.rresp;
  assign rdata     = {24'h000000, s_reg.rdata};

  // ==========================================================
  // checks
  property p_sample_taken;
    @(posedge sys_clk) disable iff (!reset_n)
      tick |=> s_reg.sensor_reading == $past(s_reg.sync2);
  endproperty
  a_sample_taken: assert property (p_sample_taken)
    else $error("sample not stored on tick");

  property p_alu_restart;
    @(posedge sys_clk) disable iff (!reset_n)
      tick && s_reg.state == PATH_IDLE |=> alu_start ##1 !alu_start;
  endproperty
  a_alu_restart: assert property (p_alu_restart)
    else $error("alu start not a single pulse after tick");

  property p_power_up;
    @(posedge sys_clk) disable iff (!reset_n)
      !$past(reset_n) |-> s_reg.ovr_ctl == OVR_CTL_RESET && !s_reg.full_access;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("override or access state not clear after reset");

  property p_temp_route;
    @(posedge sys_clk) disable iff (!reset_n)
      alu_start && $past(s_reg.ovr_ctl[OVR_TEMP_BIT]) |-> alu_temp == $past(s_reg.forced_temp);
  endproperty
  a_temp_route: assert property (p_temp_route)
    else $error("forced temperature not sent to alu");

  property p_sensor_route;
    @(posedge sys_clk) disable iff (!reset_n)
      alu_start && !$past(s_reg.ovr_ctl[OVR_TEMP_BIT]) |-> alu_temp == $past(s_reg.sync2);
  endproperty
  a_sensor_route: assert property (p_sensor_route)
    else $error("sensor sample not sent to alu");

  property p_high_held;
    @(posedge sys_clk) disable iff (!reset_n)
      wr_exec && wr_idx == IDX_FTEMP_HIGH |=> $stable(s_reg.forced_temp);
  endproperty
  a_high_held: assert property (p_high_held)
    else $error("high nibble took effect early");

  property p_low_commit;
    @(posedge sys_clk) disable iff (!reset_n)
      wr_exec && wr_idx == IDX_FTEMP_LOW && s_reg.full_access && s_reg.w_lane0
      |=> s_reg.forced_temp == {$past(s_reg.temp_hold), $past(s_reg.w_data)};
  endproperty
  a_low_commit: assert property (p_low_commit)
    else $error("forced temperature not assembled");

  property p_locked_out;
    @(posedge sys_clk) disable iff (!reset_n)
      wr_exec && !s_reg.full_access && wr_idx == IDX_OVR_CTL |=> $stable(s_reg.ovr_ctl);
  endproperty
  a_locked_out: assert property (p_locked_out)
    else $error("locked write changed control");

  property p_key_grant;
    @(posedge sys_clk) disable iff (!reset_n)
      wr_exec && wr_idx == IDX_ACCESS && s_reg.w_lane0 && s_reg.key_armed
      && s_reg.w_data == KEY_SECOND |=> s_reg.full_access;
  endproperty
  a_key_grant: assert property (p_key_grant)
    else $error("key sequence did not grant access");
endmodule
`default_nettype wire

// file: testbench/alu_model.sv
/*
  ALU stand-in on the far side of the sample path: answers each start
  after lat+1 cycles with words made from the index temperature.
  Assumes it shares sys_clk and reset_n with the block.
*/
`default_nettype none
module alu_model (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  lat,
  input  wire logic        alu_start,
  input  wire logic [11:0] alu_temp,
  output logic             alu_done,
  output logic      [11:0] alu_word0,
  output logic      [11:0] alu_word1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cnt;
  logic [11:0] t;
  logic        busy;
  // ==========================================================
  // words are inverted outside done so stale data never looks valid
  always @(posedge sys_clk) begin
    alu_done <= 1'b0;
    alu_word0 <= ~alu_word0;
    alu_word1 <= ~alu_word1;
    if (!reset_n) begin
      busy <= 1'b0;
      alu_word0 <= 12'h000;
      alu_word1 <= 12'h000;
    end else if (alu_start) begin
      busy <= 1'b1;
      cnt <= lat;
      t <= alu_temp;
    end else if (busy && cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (busy) begin
      busy <= 1'b0;
      alu_done <= 1'b1;
      alu_word0 <= t ^ 12'hA5A;
      alu_word1 <= t + 12'h111;
    end
  end
endmodule
`default_nettype wire

// file: testbench/temp_dac_path_mode_control_tb.sv
/*
  Self-checking bench: AXI4-Lite host tasks, sensor and nv inputs.
  Assumes the package constants and a short sample period of 16.
*/
`default_nettype none
module temp_dac_path_mode_control_tb
  import temp_dac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk = 0, reset_n = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0]       wdata = '0, rdata;
  logic [3:0]        wstrb = 4'h1;
  logic              awready, wready, bvalid, arready, rvalid, alu_start, alu_done;
  logic [1:0]        bresp, rresp, nv_skip = 2'b01;
  logic [11:0]       sensor_temp = 12'h123, nv_base0 = 12'h5A3, nv_base1 = 12'h3C4;
  logic [11:0]       alu_temp, alu_word0, alu_word1, dac_word0, dac_word1, t;
  logic [7:0]        lat = 8'h00;
  logic [31:0]       d;
  logic [1:0]        r;
  int                errors = 0, n_tests = 0;

  always #12.5 sys_clk = ~sys_clk;

  temp_dac_path_mode_control #(.SAMPLE_CYCLES_P(16)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sensor_temp(sensor_temp), .alu_start(alu_start), .alu_temp(alu_temp),
    .alu_done(alu_done), .alu_word0(alu_word0), .alu_word1(alu_word1), .nv_skip(nv_skip),
    .nv_base0(nv_base0), .nv_base1(nv_base1), .dac_word0(dac_word0), .dac_word1(dac_word1));

  alu_model alu (.sys_clk(sys_clk), .reset_n(reset_n), .lat(lat), .alu_start(alu_start),
    .alu_temp(alu_temp), .alu_done(alu_done), .alu_word0(alu_word0), .alu_word1(alu_word1));

  // ==========================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // bus tasks: handshakes judged at the negedge before the taking edge
  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    logic a, w, b;
    int   k;
    b = 0;
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (k = 0; k < 50 && !b; k++) begin
      @(negedge sys_clk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = (bvalid === 1'b1);
      if (b) chk("bresp", RESP_OKAY, bresp);
      @(posedge sys_clk);
      if (a) awvalid <= 0;
      if (w) wvalid <= 0;
      if (b) bready <= 0;
    end
    if (!b) chk("write_answer", 1, 0);
  endtask

  task automatic rd(input logic [5:0] idx);
    logic a, b;
    int   k;
    b = 0;
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    for (k = 0; k < 50 && !b; k++) begin
      @(negedge sys_clk);
      a = arvalid && arready;
      b = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (a) arvalid <= 0;
      if (b) rready <= 0;
    end
    if (!b) chk("read_answer", 1, 0);
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] e, input string nm);
    rd(idx);
    chk(nm, {24'h0, e}, d);
  endtask

  // first look at a negedge, so a pulse seen by the last call is not caught twice
  task automatic wait_start;
    int k;
    @(negedge sys_clk);
    for (k = 0; k < 100 && alu_start !== 1'b1; k++) @(negedge sys_clk);
    if (k == 100) chk("alu_start", 1, 0);
    t = alu_temp;
    @(posedge sys_clk);
  endtask

  task automatic wait_dac1(input logic [11:0] e);
    int k;
    for (k = 0; k < 60 && dac_word1 !== e; k++) @(negedge sys_clk);
    chk("dac_word1", e, dac_word1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1;
    repeat (3) @(negedge sys_clk);
    chk("dac_word0", nv_base0, dac_word0);
    chk("dac_word1", 0, dac_word1);
    rdchk(IDX_OVR_CTL, 8'h00, "ovr_ctl");
    rdchk(IDX_FTEMP_LOW, 8'h00, "ftemp_low");
    wait_start;
    chk("alu_temp", 12'h123, t);
    wait_dac1(12'h234);
    rdchk(IDX_CALC1_LOW, 8'h34, "calc1_low");
    chk("dac_word0", nv_base0, dac_word0);
    rdchk(IDX_SENSOR_HIGH, 8'h01, "sensor_high");
    rdchk(IDX_SENSOR_LOW, 8'h23, "sensor_low");
    // locked and broken-key writes must leave control untouched
    wr(IDX_OVR_CTL, 8'h02);
    wr(IDX_ACCESS, KEY_FIRST);
    wr(IDX_ACCESS, 8'h12);
    wr(IDX_OVR_CTL, 8'h02);
    rdchk(IDX_OVR_CTL, 8'h00, "ovr_ctl");
    rdchk(IDX_ACCESS, ACCESS_NONE_RD, "access");
    wr(IDX_ACCESS, KEY_FIRST);
    wr(IDX_ACCESS, KEY_SECOND);
    rdchk(IDX_ACCESS, ACCESS_FULL_RD, "access");
    wr(IDX_FTEMP_HIGH, 8'h08);
    rdchk(IDX_FTEMP_HIGH, 8'h00, "ftemp_high");
    wr(IDX_FTEMP_LOW, 8'h01);
    rdchk(IDX_FTEMP_HIGH, 8'h08, "ftemp_high");
    sensor_temp <= 12'h0F7;
    wr(IDX_OVR_CTL, 8'h01);
    wait_start;
    wait_start;
    chk("alu_temp", 12'h801, t);
    wait_dac1(12'h912);
    rdchk(IDX_SENSOR_HIGH, 8'h00, "sensor_high");
    rdchk(IDX_SENSOR_LOW, 8'hF7, "sensor_low");
    lat <= 8'd9;
    wr(IDX_OVR_CTL, 8'h00);
    wait_start;
    wait_start;
    chk("alu_temp", 12'h0F7, t);
    wait_dac1(12'h208);
    wr(IDX_FDAC0_HIGH, 8'h08);
    wr(IDX_FDAC0_LOW, 8'h00);
    wr(IDX_FDAC1_HIGH, 8'h04);
    wr(IDX_FDAC1_LOW, 8'h00);
    wr(IDX_OVR_CTL, 8'h02);
    repeat (3) @(negedge sys_clk);
    chk("dac_word0", 12'h800, dac_word0);
    chk("dac_word1", 12'h400, dac_word1);
    wait_start;
    repeat (14) @(negedge sys_clk);
    chk("dac_word1", 12'h400, dac_word1);
    wr(IDX_BASE1_HIGH, 8'h86);
    wr(IDX_BASE1_LOW, 8'h55);
    wr(IDX_OVR_CTL, 8'h00);
    repeat (3) @(negedge sys_clk);
    chk("dac_word1", 12'h655, dac_word1);
    chk("dac_word0", nv_base0, dac_word0);
    rd(6'h3F);
    chk("rresp", RESP_SLVERR, r);
    chk("rdata_unmapped", 0, d);
    summarize;
  end

  initial begin
    #(25ns * 20000);
    errors++;
    summarize;
  end
endmodule
`default_nettype wire
